// >>> rtl/otwp_cfg.svh
`ifndef OTWP_CFG_SVH
`define OTWP_CFG_SVH

// ----------------------------------------------------------------------
// File addresses
// ----------------------------------------------------------------------
`define OTWP_ADDR_COUNT     8'h01
`define OTWP_ADDR_IRQ_CTRL  8'h0B
`define OTWP_ADDR_OPTION    8'h81

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OTWP_OPT_ASSIGN_BIT 3
`define OTWP_OPT_RATIO_MSB  2
`define OTWP_OPT_RATIO_LSB  0
`define OTWP_IRQ_ENABLE_BIT 5
`define OTWP_IRQ_FLAG_BIT   2

// ----------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------
`define OTWP_RST_COUNT      8'h00
`define OTWP_RST_OPTION     8'hFF
`define OTWP_RST_IRQ_CTRL   8'h00
`define OTWP_WR_INHIBIT     2'h2

`endif

// >>> rtl/otwp_pkg.sv
package otwp_pkg;

  // One access from the CPU to the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } otwp_file_req_type;

endpackage : otwp_pkg

// >>> rtl/otwp_prescaler.sv
`timescale 1ns/1ns
`include "otwp_cfg.svh"

module otwp_prescaler #(
  parameter int WIDTH = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       clear_i,
  input  wire logic [2:0] ratio_i,
  output logic            tick_o
);
  import otwp_pkg::*;

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] mask;

  // Ratio field n selects divide by 2^(n+1)
  assign mask   = WIDTH'((9'h002 << ratio_i) - 9'h001);
  assign tick_o = tick_i && ((cnt_reg & mask) == mask);

  // Not readable or writable; only cleared
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      cnt_reg <= '0;
    else if (tick_i)
      cnt_reg <= WIDTH'(cnt_reg + 1'b1);
  end

  clear_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_i |=> cnt_reg == '0)
    else $error("prescaler not cleared");

  out_ratio_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_o && !clear_i) |=> (cnt_reg & mask) == '0 || $changed(ratio_i))
    else $error("prescaler output off ratio");

endmodule : otwp_prescaler

// >>> rtl/otwp_timer.sv
`timescale 1ns/1ns
`include "otwp_cfg.svh"


module otwp_timer (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire otwp_pkg::otwp_file_req_type file_req_i,
  input  wire logic                       sleep_i,
  input  wire logic                       wdt_tick_i,
  input  wire logic                       wdt_clear_i,
  output logic [7:0]                      file_rdata_o,
  output logic                            irq_o,
  output logic                            wdt_post_tick_o
);
  import otwp_pkg::*;

  // --------------------------------------------------------------------
  // Register file decode
  // --------------------------------------------------------------------
  logic       wr_count;
  logic       wr_irq;
  logic       wr_option;
  logic [7:0] timer_count_reg;
  logic [7:0] option_reg;
  logic       overflow_flag_reg;
  logic       overflow_irq_enable_reg;
  logic [1:0] inhibit_reg;
  logic       prescaler_assign_sel;
  logic [2:0] prescale_ratio_sel;
  logic       ps_tick_in;
  logic       ps_clear;
  logic       ps_tick_out;
  logic       run;
  logic       inc;
  logic       wrap;
  logic [7:0] rd_value;

  assign wr_count  = file_req_i.wr && file_req_i.addr == `OTWP_ADDR_COUNT;
  assign wr_irq    = file_req_i.wr && file_req_i.addr == `OTWP_ADDR_IRQ_CTRL;
  assign wr_option = file_req_i.wr && file_req_i.addr == `OTWP_ADDR_OPTION;

  assign prescaler_assign_sel = option_reg[`OTWP_OPT_ASSIGN_BIT];
  assign prescale_ratio_sel   =
    option_reg[`OTWP_OPT_RATIO_MSB:`OTWP_OPT_RATIO_LSB];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      option_reg <= `OTWP_RST_OPTION;
    else if (wr_option)
      option_reg <= file_req_i.wdata;
  end

  // --------------------------------------------------------------------
  // Shared prescaler
  // --------------------------------------------------------------------
  // Whichever side does not own it sees no division at all
  assign run        = !sleep_i;
  assign ps_tick_in = prescaler_assign_sel ? wdt_tick_i : run;
  assign ps_clear   = prescaler_assign_sel ? wdt_clear_i : wr_count;

  otwp_prescaler #(
    .WIDTH (8)
  ) u_prescaler (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (ps_tick_in),
    .clear_i (ps_clear),
    .ratio_i (prescale_ratio_sel),
    .tick_o  (ps_tick_out)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wdt_post_tick_o <= 1'b0;
    else
      wdt_post_tick_o <= prescaler_assign_sel ? ps_tick_out : wdt_tick_i;
  end

  // --------------------------------------------------------------------
  // Count
  // --------------------------------------------------------------------
  // Hold-off after a write; software must pre-compensate for it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      inhibit_reg <= 2'h0;
    else if (wr_count)
      inhibit_reg <= `OTWP_WR_INHIBIT;
    else if (inhibit_reg != 2'h0)
      inhibit_reg <= 2'(inhibit_reg - 2'h1);
  end

  assign inc  = run && !wr_count && inhibit_reg == 2'h0 &&
                (prescaler_assign_sel ? 1'b1 : ps_tick_out);
  assign wrap = inc && timer_count_reg == 8'hFF;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_count_reg <= `OTWP_RST_COUNT;
    else if (wr_count)
      timer_count_reg <= file_req_i.wdata;
    else if (inc)
      timer_count_reg <= 8'(timer_count_reg + 8'h01);
  end

  // --------------------------------------------------------------------
  // Overflow flag and interrupt gate
  // --------------------------------------------------------------------
  // A wrap in the same cycle as a software clear keeps the flag set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overflow_flag_reg <= 1'b0;
    else if (wrap)
      overflow_flag_reg <= 1'b1;
    else if (wr_irq)
      overflow_flag_reg <= file_req_i.wdata[`OTWP_IRQ_FLAG_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      overflow_irq_enable_reg <= 1'b0;
    else if (wr_irq)
      overflow_irq_enable_reg <= file_req_i.wdata[`OTWP_IRQ_ENABLE_BIT];
  end

  assign irq_o = overflow_flag_reg && overflow_irq_enable_reg;

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always_comb
  begin
    rd_value = 8'h00;
    case (file_req_i.addr)
      `OTWP_ADDR_COUNT:    rd_value = timer_count_reg;
      `OTWP_ADDR_OPTION:   rd_value = option_reg;
      `OTWP_ADDR_IRQ_CTRL:
      begin
        rd_value[`OTWP_IRQ_ENABLE_BIT] = overflow_irq_enable_reg;
        rd_value[`OTWP_IRQ_FLAG_BIT]   = overflow_flag_reg;
      end
      default:             rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      file_rdata_o <= 8'h00;
    else if (file_req_i.rd)
      file_rdata_o <= rd_value;
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  count_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap |=> timer_count_reg == 8'h00 && overflow_flag_reg)
    else $error("count did not wrap with flag");

  count_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_count |=> timer_count_reg == $past(file_req_i.wdata))
    else $error("count write not loaded");

  write_holdoff_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wr_count ##1 !wr_count ##1 !wr_count) |->
      timer_count_reg == $past(file_req_i.wdata, 2))
    else $error("count moved during hold-off");

  direct_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (prescaler_assign_sel && run && !wr_count && inhibit_reg == 2'h0) |=>
      timer_count_reg == 8'($past(timer_count_reg) + 8'h01))
    else $error("count missed a cycle");

  sleep_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_i && !wr_count && !wr_irq) |=> $stable(timer_count_reg) &&
      !$rose(overflow_flag_reg))
    else $error("timer ran in sleep");

  flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (overflow_flag_reg && !wr_irq) |=> overflow_flag_reg)
    else $error("flag dropped without clear");

  irq_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!overflow_irq_enable_reg && !wr_irq) |=> !irq_o)
    else $error("masked interrupt raised");

  read_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (file_req_i.rd && file_req_i.addr == `OTWP_ADDR_COUNT) |=>
      file_rdata_o == $past(timer_count_reg))
    else $error("count read wrong");

  wdt_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !prescaler_assign_sel |=> wdt_post_tick_o == $past(wdt_tick_i))
    else $error("watchdog tick not passed straight through");

  write_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_count && !prescaler_assign_sel) |=> !ps_tick_out)
    else $error("prescaler not restarted by count write");

endmodule : otwp_timer

// >>> verif/overflow_timer_with_prescaler_bench.sv
`timescale 1ns/1ns
module overflow_timer_with_prescaler_bench;
  import otwp_pkg::*;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end

  logic              clk_i       = 1'b0;
  logic              rst_i       = 1'b1;
  logic              sleep_i     = 1'b0;
  logic              wdt_tick_i  = 1'b0;
  logic              wdt_clear_i = 1'b0;
  otwp_file_req_type file_req_i  = '0;
  logic [7:0]        file_rdata_o;
  logic              irq_o;
  logic              wdt_post_tick_o;
  int                n_errors    = 0;
  int                tests_run   = 0;
  int                cycles      = 0;
  int                k;
  int                n;

  otwp_timer u_otwp_timer (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .file_req_i      (file_req_i),
    .sleep_i         (sleep_i),
    .wdt_tick_i      (wdt_tick_i),
    .wdt_clear_i     (wdt_clear_i),
    .file_rdata_o    (file_rdata_o),
    .irq_o           (irq_o),
    .wdt_post_tick_o (wdt_post_tick_o)
  );

  always #2 clk_i = ~clk_i;

  // ------------------------------------------------------------------
  // Verdict and hang guard
  // ------------------------------------------------------------------
  task report_and_stop;
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  // Request is held through one edge and left standing, so back to back
  // accesses never assign the bus twice in one time step
  task req(input logic w, input logic r, input logic [7:0] a,
           input logic [7:0] d);
    file_req_i = '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk_i);
    #1;
  endtask : req

  task rd(input logic [7:0] a, input logic [7:0] e);
    req(1'b0, 1'b1, a, 8'h00);
    `CHK(file_rdata_o, e)
  endtask : rd

  task idle(input int c);
    repeat (c) req(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task reset_values;
    rd(8'h81, 8'hFF);
    rd(8'h0B, 8'h00);
    rd(8'h55, 8'h00);
  endtask : reset_values

  task write_hold_and_wrap;
    req(1'b1, 1'b0, 8'h01, 8'hFE);
    rd(8'h01, 8'hFE);
    rd(8'h01, 8'hFE);
    rd(8'h01, 8'hFE);
    rd(8'h01, 8'hFF);
    rd(8'h01, 8'h00);
    rd(8'h0B, 8'h04);
    `CHK(irq_o, 1'b0)
    req(1'b1, 1'b0, 8'h0B, 8'h24);
    `CHK(irq_o, 1'b1)
    idle(3);
    rd(8'h0B, 8'h24);
    req(1'b1, 1'b0, 8'h0B, 8'h20);
    `CHK(irq_o, 1'b0)
    req(1'b1, 1'b0, 8'h0B, 8'h00);
  endtask : write_hold_and_wrap

  task prescale_ratios;
    for (k = 0; k < 8; k++)
    begin
      req(1'b1, 1'b0, 8'h81, {5'h00, k[2:0]});
      req(1'b1, 1'b0, 8'h01, 8'h00);
      idle(4 << (k + 1));
      req(1'b0, 1'b1, 8'h01, 8'h00);
      `CHK(file_rdata_o, (k == 0) ? 8'h03 : 8'h04)
    end
  endtask : prescale_ratios

  task sleep_halt;
    req(1'b1, 1'b0, 8'h81, 8'h08);
    req(1'b1, 1'b0, 8'h01, 8'h10);
    sleep_i = 1'b1;
    idle(4);
    req(1'b0, 1'b1, 8'h01, 8'h00);
    `CHK(file_rdata_o, 8'h10)
    idle(6);
    rd(8'h01, 8'h10);
    sleep_i = 1'b0;
  endtask : sleep_halt

  task watchdog_share;
    req(1'b1, 1'b0, 8'h81, 8'h00);
    wdt_tick_i = 1'b1;
    idle(1);
    wdt_tick_i = 1'b0;
    `CHK(wdt_post_tick_o, 1'b1)
    req(1'b1, 1'b0, 8'h81, 8'h08);
    wdt_clear_i = 1'b1;
    idle(1);
    wdt_clear_i = 1'b0;
    wdt_tick_i = 1'b1;
    n = 0;
    for (k = 0; k < 7; k++)
    begin
      idle(1);
      if (k == 3)
        wdt_tick_i = 1'b0;
      `CHK(wdt_post_tick_o, k == 1 || k == 3)
      n += int'(wdt_post_tick_o);
    end
    `CHK(n, 2)
  endtask : watchdog_share

  initial
  begin
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    reset_values();
    write_hold_and_wrap();
    prescale_ratios();
    sleep_halt();
    watchdog_share();
    report_and_stop();
  end
endmodule : overflow_timer_with_prescaler_bench
